// ### rtl/tcs_transfer_sequencer.sv
// Implementation choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/100ps
module tcs_transfer_sequencer
(
   input wire logic MCLK_I, // 100 MHz clock
   input wire logic ARST_N_I, // async reset, active low
   input wire logic CE_I, // clock enable, freezes all state when low
   input wire logic [3:0] AVS_ADDRESS_I, // Avalon byte address
   input wire logic AVS_READ_I, // Avalon read
   input wire logic AVS_WRITE_I, // Avalon write
   input wire logic [31:0] AVS_WRITEDATA_I, // Avalon write data
   input wire logic [3:0] AVS_BYTEENABLE_I, // Avalon byte enables
   output logic [31:0] AVS_READDATA_O, // Avalon read data
   output logic AVS_WAITREQUEST_O, // Avalon wait request
   input wire logic STAGE1_FULL_I, // first buffer stage holds data
   input wire logic STAGE2_FULL_I, // second buffer stage holds data
   input wire logic WRITE_MOTION_I, // write motion active
   input wire logic READ_MOTION_I, // read motion active
   input wire logic MOTION_START_STROBE_I, // motion start pulse
   input wire logic WRITE_MOTION_START_I, // write motion start pulse
   input wire logic BUFFERED_START_STROBE_I, // buffered transfer start pulse
   input wire logic REGISTER_READ_STROBE_I, // register channel read pulse
   input wire logic REGISTER_WRITE_STROBE_I, // register channel write pulse
   input wire logic CONTROLLER_CLEAR_I, // controller clear pulse
   input wire logic FILE_MARK_I, // file mark detected
   input wire logic END_OF_TAPE_I, // end of tape level
   input wire logic LAST_WORD_I, // last word level
   input wire logic BUSY_I, // transport busy level
   input wire logic PROTECT_I, // channel protect bit
   input wire logic ADDR_INCREMENT_PULSE_I, // address increment pulse
   input wire logic READ_CHAR_STROBE_I, // tape read character strobe pin
   input wire logic PHASE_WRITE_REQUEST_I, // phase encoding write request pin
   input wire logic RESUME_I, // storage channel resume pin
   input wire logic PARITY_FAULT_I, // computer parity fault pin
   input wire logic PROTECT_FAULT_I, // computer protect violation pin
   input wire logic SCAN_IN_I, // scanner input pin
   output logic SCAN_OUT_O, // scanner output
   output logic STAGE_MOVE_PULSE_O, // move first stage into second
   output logic DATA_REQUEST_O, // register channel data request
   output logic LOST_DATA_O, // lost data flag
   output logic WRITE_END_O, // legal end of register write pulse
   output logic WRITE_CHAR_STROBE_O, // character write strobe
   output logic ADVANCE_WRITE_STROBE_O, // early write strobe
   output logic LOCKOUT_O, // lockout pulse
   output logic FIRST_WORD_PENDING_O, // first word not yet written
   output logic RECORD_END_SEQUENCE_O, // end of record sequence flag
   output logic CYCLIC_CHECK_CHAR_O, // cyclic check character state
   output logic LONGITUDINAL_CHECK_CHAR_O, // longitudinal check character state
   output logic BLOCK_ACTIVE_O, // block transfer active
   output logic FETCH_LIMIT_WORD_O, // fetching limit word
   output logic CHANNEL_PROTECT_O, // captured protect bit
   output logic LIMIT_ADDR_LOAD_O, // limit latch load, low while armed
   output logic REQUEST_O, // storage channel request
   output logic WORD_STROBE_O, // word into or out of buffer pulse
   output logic MEMORY_WRITE_ENABLE_O, // memory write enable
   output logic GAP_TIMING_CLOCK_O, // gap clock
   output logic PHASE_CHAR_CLOCK_O, // phase encoding character clock
   output logic PHASE_BIT_CLOCK_O // phase encoding bit clock
);
   import tcs_pkg::*;
   //------------------------------------------------------------------
   // Pin synchronisers
   //------------------------------------------------------------------
   logic [NSYNC-1:0] pin_raw, sy1_r, sy2_r, sy3_r;
   assign pin_raw = {SCAN_IN_I, PROTECT_FAULT_I, PARITY_FAULT_I, RESUME_I,
                     PHASE_WRITE_REQUEST_I, READ_CHAR_STROBE_I};
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++)
      begin : g_sync
         always_ff @(posedge MCLK_I or negedge ARST_N_I)
         begin
            if (!ARST_N_I)
            begin
               sy1_r[gi] <= 1'b0;
               sy2_r[gi] <= 1'b0;
               sy3_r[gi] <= 1'b0;
            end
            else if (CE_I)
            begin
               sy1_r[gi] <= pin_raw[gi];
               sy2_r[gi] <= sy1_r[gi];
               sy3_r[gi] <= sy2_r[gi];
            end
         end
      end
   endgenerate
   wire [NSYNC-1:0] pin_rise = sy2_r & ~sy3_r;
   wire [NSYNC-1:0] pin_fall = ~sy2_r & sy3_r;
   //------------------------------------------------------------------
   // Register slave
   //------------------------------------------------------------------
   logic [31:0] ctrl_r, rdata_r, status_w, clocks_w;
   logic ack_r;
   wire access = AVS_READ_I | AVS_WRITE_I;
   // A write lands only at the completing edge, where waitrequest is seen low.
   wire wr_ctrl = AVS_WRITE_I & ack_r & (AVS_ADDRESS_I == ADDR_CTRL);
   wire [31:0] be_mask = {{8{AVS_BYTEENABLE_I[3]}}, {8{AVS_BYTEENABLE_I[2]}},
                          {8{AVS_BYTEENABLE_I[1]}}, {8{AVS_BYTEENABLE_I[0]}}};
   wire [31:0] rd_mux = (AVS_ADDRESS_I == ADDR_CTRL) ? ctrl_r :
                        (AVS_ADDRESS_I == ADDR_STATUS) ? status_w :
                        (AVS_ADDRESS_I == ADDR_CLOCKS) ? clocks_w : 32'h0000_0000;
   assign AVS_WAITREQUEST_O = access & ~ack_r;
   assign AVS_READDATA_O = rdata_r;
   wire fast = ctrl_r[CTRL_FAST];
   wire speed_hi = ctrl_r[CTRL_SPEED];
   wire pe_mode = ctrl_r[CTRL_PE];
   wire seven_track = ctrl_r[CTRL_7T];
   wire write_mark = ctrl_r[CTRL_WFM];
   always_ff @(posedge MCLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         ctrl_r <= CTRL_RESET;
         ack_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
      end
      else if (CE_I)
      begin
         ack_r <= access & ~ack_r;
         if (AVS_READ_I & ~ack_r)
            rdata_r <= rd_mux;
         if (wr_ctrl)
            ctrl_r <= ((ctrl_r & ~be_mask) | (AVS_WRITEDATA_I & be_mask)) & 32'h0000_001F;
      end
   end
   //------------------------------------------------------------------
   // Basic timing: phase ticks and dividers
   //------------------------------------------------------------------
   // Each tick is a level a quarter period wide; logic acts on its rising edge.
   logic [7:0] ph_cnt_r;
   logic [4:0] div_r, tap_prev_r, wclk_cnt_r;
   logic [3:0] gap_cnt_r;
   logic gap_r, wclk_r, wclk_prev_r, char_clk_r, bit_clk_r;
   wire [7:0] ph_len = fast ? 8'(TICK_FAST_CYC) : 8'(TICK_SLOW_CYC);
   wire [7:0] ph_last = ph_len - 8'h01;
   wire t1_edge = (ph_cnt_r == 8'h00);
   wire t3_edge = (ph_cnt_r == {1'b0, ph_len[7:1]});
   wire t1_lvl = (ph_cnt_r < {2'b00, ph_len[7:2]});
   // Divider chain on tick one; jumper moves all taps one stage.
   wire [4:0] div_nxt = div_r + 5'h01;
   wire [3:0] taps = speed_hi ? {div_r[3], div_r[1], div_r[0], t1_lvl}
                              : {div_r[4], div_r[2], div_r[1], div_r[0]};
   wire [3:0] tap_rise = taps & ~tap_prev_r[3:0];
   wire fast_tap_ev = speed_hi ? t1_edge : (t1_edge & tap_rise[0]);
   wire char_tap_ev = t1_edge & tap_rise[2];
   wire wclk_fall = wclk_prev_r & ~wclk_r;
   wire wclk_rise = ~wclk_prev_r & wclk_r;
   always_ff @(posedge MCLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         ph_cnt_r <= 8'h00;
         div_r <= 5'h00;
         tap_prev_r <= 5'h00;
         gap_cnt_r <= 4'h0;
         wclk_cnt_r <= 5'h00;
         gap_r <= 1'b0;
         wclk_r <= 1'b0;
         wclk_prev_r <= 1'b0;
         char_clk_r <= 1'b0;
         bit_clk_r <= 1'b0;
      end
      else if (CE_I)
      begin
         ph_cnt_r <= (ph_cnt_r >= ph_last) ? 8'h00 : ph_cnt_r + 8'h01;
         wclk_prev_r <= wclk_r;
         if (t1_edge)
         begin
            div_r <= div_nxt;
            tap_prev_r <= {1'b0, taps};
         end
         if (t3_edge)
            bit_clk_r <= taps[1];
         if (char_tap_ev)
         begin
            char_clk_r <= ~char_clk_r;
            gap_cnt_r <= (gap_cnt_r == 4'(GAP_DIV - 1)) ? 4'h0 : gap_cnt_r + 4'h1;
            if (gap_cnt_r == 4'(GAP_DIV - 1))
               gap_r <= 1'b1;
         end
         else if (t3_edge && gap_cnt_r == 4'(GAP_HIGH))
            gap_r <= 1'b0;
         if (fast_tap_ev)
         begin
            wclk_cnt_r <= (wclk_cnt_r == 5'(WCLK_DIV - 1)) ? 5'h00 : wclk_cnt_r + 5'h01;
            if (wclk_cnt_r == 5'(WCLK_DIV - 1))
               wclk_r <= 1'b1;
         end
         else if (t3_edge && wclk_cnt_r == 5'(WCLK_HIGH))
            wclk_r <= 1'b0;
      end
   end
   assign GAP_TIMING_CLOCK_O = gap_r;
   assign PHASE_CHAR_CLOCK_O = char_clk_r;
   assign PHASE_BIT_CLOCK_O = bit_clk_r;
   //------------------------------------------------------------------
   // Write strobes, first word and lockout
   //------------------------------------------------------------------
   logic shifted_r, first_r, first_adv_done_r, lockout_r;
   // Outside phase encoding, the early strobe leads the character strobe by the write clock high time.
   wire adv_strobe = WRITE_MOTION_I & wclk_rise;
   wire write_char_strobe = WRITE_MOTION_I & (pe_mode ? pin_rise[SY_PHASE_WRITE_REQUEST] : wclk_fall);
   always_ff @(posedge MCLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         shifted_r <= 1'b0;
         first_r <= 1'b0;
         first_adv_done_r <= 1'b0;
         lockout_r <= 1'b0;
      end
      else if (CE_I)
      begin
         shifted_r <= write_char_strobe;
         if (MOTION_START_STROBE_I)
            first_r <= 1'b1;
         else if (wclk_fall)
            first_r <= 1'b0;
         first_adv_done_r <= ~MOTION_START_STROBE_I & (first_adv_done_r | adv_strobe);
         lockout_r <= adv_strobe & ~first_adv_done_r & ~STAGE2_FULL_I;
      end
   end
   assign WRITE_CHAR_STROBE_O = write_char_strobe;
   assign ADVANCE_WRITE_STROBE_O = adv_strobe;
   assign LOCKOUT_O = lockout_r;
   assign FIRST_WORD_PENDING_O = first_r;
   //------------------------------------------------------------------
   // Record end and check character counter
   //------------------------------------------------------------------
   logic eor_r;
   logic [3:0] chk_r;
   wire eor_set = adv_strobe & (~STAGE2_FULL_I | (first_r & write_mark));
   always_ff @(posedge MCLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         eor_r <= 1'b0;
         chk_r <= CHK_PRESET_9T;
      end
      else if (CE_I)
      begin
         if (eor_set)
            eor_r <= 1'b1;
         else if (!WRITE_MOTION_I || CONTROLLER_CLEAR_I)
            eor_r <= 1'b0;
         if (!eor_r)
            chk_r <= seven_track ? CHK_PRESET_7T : CHK_PRESET_9T;
         else if (shifted_r && chk_r != CHK_LOCK)
            chk_r <= chk_r + 4'h1;
      end
   end
   assign RECORD_END_SEQUENCE_O = eor_r;
   assign CYCLIC_CHECK_CHAR_O = eor_r & ~chk_r[0] & chk_r[1] & ~chk_r[2];
   assign LONGITUDINAL_CHECK_CHAR_O = eor_r & ~chk_r[0] & chk_r[1] & chk_r[2];
   //------------------------------------------------------------------
   // Stage move, data request and lost data
   //------------------------------------------------------------------
   logic move_r, req_data_r, lost_r, wend_r, block_r, stop_prev_r;
   wire move_rise = move_r;
   wire lost_set = (pin_rise[SY_RCS] & STAGE1_FULL_I & (block_r | LAST_WORD_I))
                 | (block_r & write_char_strobe & ~STAGE2_FULL_I);
   wire data_clr = REGISTER_READ_STROBE_I | REGISTER_WRITE_STROBE_I | eor_r | lost_r
                 | FILE_MARK_I | CONTROLLER_CLEAR_I | END_OF_TAPE_I;
   wire data_set = ~block_r & (move_rise | WRITE_MOTION_START_I);
   always_ff @(posedge MCLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         move_r <= 1'b0;
         req_data_r <= 1'b0;
         lost_r <= 1'b0;
         wend_r <= 1'b0;
      end
      else if (CE_I)
      begin
         move_r <= t1_edge & STAGE1_FULL_I & ~STAGE2_FULL_I & ~move_r;
         if (data_set)
            req_data_r <= 1'b1;
         else if (data_clr)
            req_data_r <= 1'b0;
         if (lost_set)
            lost_r <= 1'b1;
         else if (CONTROLLER_CLEAR_I)
            lost_r <= 1'b0;
         wend_r <= ~block_r & write_char_strobe & ~STAGE2_FULL_I;
      end
   end
   assign STAGE_MOVE_PULSE_O = move_r;
   assign DATA_REQUEST_O = req_data_r;
   assign LOST_DATA_O = lost_r;
   assign WRITE_END_O = wend_r;
   //------------------------------------------------------------------
   // Buffered transfer control
   //------------------------------------------------------------------
   logic fetch_r, prot_r, lim_r;
   wire stop_now = eor_r | lost_r | END_OF_TAPE_I | (LAST_WORD_I & (END_OF_TAPE_I | BUSY_I));
   always_ff @(posedge MCLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         block_r <= 1'b0;
         fetch_r <= 1'b0;
         prot_r <= 1'b0;
         lim_r <= 1'b1;
         stop_prev_r <= 1'b0;
      end
      else if (CE_I)
      begin
         stop_prev_r <= stop_now;
         if (BUFFERED_START_STROBE_I)
         begin
            block_r <= 1'b1;
            fetch_r <= 1'b1;
            prot_r <= PROTECT_I;
         end
         else if (CONTROLLER_CLEAR_I)
         begin
            block_r <= 1'b0;
            fetch_r <= 1'b0;
            prot_r <= 1'b0;
         end
         else if (stop_now & ~stop_prev_r)
            block_r <= 1'b0;
         if (BUFFERED_START_STROBE_I)
            lim_r <= 1'b0;
         else if (ADDR_INCREMENT_PULSE_I)
            lim_r <= 1'b1;
      end
   end
   assign BLOCK_ACTIVE_O = block_r;
   assign FETCH_LIMIT_WORD_O = fetch_r;
   assign CHANNEL_PROTECT_O = prot_r;
   assign LIMIT_ADDR_LOAD_O = lim_r;
   //------------------------------------------------------------------
   // Scanner and request / resume
   //------------------------------------------------------------------
   logic need_r, hold_r, chreq_r, grant_r, wren_r, wstb_r, par_r, pfault_r, scan_out_r;
   wire scan_rise = pin_rise[SY_SCAN];
   wire need_set = BUFFERED_START_STROBE_I | (WRITE_MOTION_START_I & block_r)
                 | (move_rise & block_r & ~lost_r);
   always_ff @(posedge MCLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         need_r <= 1'b0;
         hold_r <= 1'b0;
         chreq_r <= 1'b0;
         grant_r <= 1'b0;
         wren_r <= 1'b0;
         wstb_r <= 1'b0;
         par_r <= 1'b0;
         pfault_r <= 1'b0;
         scan_out_r <= 1'b0;
      end
      else if (CE_I)
      begin
         if (need_set)
            need_r <= 1'b1;
         else if (CONTROLLER_CLEAR_I || grant_r)
            need_r <= 1'b0;
         if (scan_rise && need_r && !hold_r && !chreq_r)
            hold_r <= 1'b1;
         else if (scan_rise && hold_r)
            hold_r <= 1'b0;
         if (scan_rise && hold_r)
            chreq_r <= 1'b1;
         else if (grant_r || CONTROLLER_CLEAR_I)
            chreq_r <= 1'b0;
         if (pin_rise[SY_RESUME])
            grant_r <= 1'b1;
         else if (pin_fall[SY_RESUME])
            grant_r <= 1'b0;
         wstb_r <= pin_fall[SY_RESUME] & grant_r;
         if (scan_rise && hold_r && READ_MOTION_I && !sy2_r[SY_RESUME])
            wren_r <= 1'b1;
         else if (pin_fall[SY_RESUME] || CONTROLLER_CLEAR_I)
            wren_r <= 1'b0;
         if (sy2_r[SY_PARITY] && grant_r)
            par_r <= 1'b1;
         else if (CONTROLLER_CLEAR_I)
            par_r <= 1'b0;
         if (sy2_r[SY_PROT] && grant_r)
            pfault_r <= 1'b1;
         else if (CONTROLLER_CLEAR_I)
            pfault_r <= 1'b0;
         // Hold blocks the scan from passing on, so the loop closes back here.
         scan_out_r <= sy2_r[SY_SCAN] & ~hold_r;
      end
   end
   assign SCAN_OUT_O = scan_out_r;
   assign REQUEST_O = chreq_r;
   assign WORD_STROBE_O = wstb_r;
   assign MEMORY_WRITE_ENABLE_O = wren_r;
   assign status_w = {16'h0000, chk_r, pfault_r, par_r, grant_r, chreq_r,
                      need_r, prot_r, fetch_r, block_r, eor_r, first_r, lost_r,
                      req_data_r};
   assign clocks_w = {26'h0000000, wclk_r, gap_r, bit_clk_r, char_clk_r, t1_lvl, hold_r};
endmodule : tcs_transfer_sequencer

// ### rtl/tcs_pkg.sv
//------------------------------------------------------------------
// Overview of operation
//------------------------------------------------------------------
// Overview of operation
// - Move first stage into empty second stage whenever first stage holds data.
// - Data request sets outside block mode, by stage move rise or write start.
// - Data request clears on read, write, record end, loss, mark, clear, tape end.
// - Lost data: read strobe with full first stage in block mode or at last word, or block-mode write strobe with empty second.
// - Empty second stage at write strobe in register mode ends writing normally.
// - Write strobe comes from write clock, or phase write request at 1600 bpi.
// - Motion start sets first-word flag; first write clock fall clears it.
// - First advance strobe with second stage not full issues one lockout pulse.
// - Four record end sequences; file mark second character is the check character.
// - Record end sets only in write motion, by advance strobe with empty second stage or mark.
// - Check counter presets 1011 or 0111, then counts shifted strobes and locks.
// - Buffered start sets block and fetch flags, captures protect; clear resets all.
// - Block flag clears on rise of end, loss, tape end, or last word with end/busy.
// - Limit load falls with fetch set, rises at first increment, then holds.
// - Need during first scan pulse sets hold; second scan arrival sets request.
// - Need sets on buffered start, block write start, block stage move; grant clears.
// - Resume leading edge sets grant; grant clears request and need.
// - Resume trailing edge clears grant, strobes word, drops memory write enable.
// - Parity and protect faults set when signalled while grant is high.
// - Timing derives from two quarter-wide phase ticks, half a cycle apart.
// - First tick divided by 2 and 32; speed jumper selects outputs.
// - Character clock halves a divider output; bit clock resampled on third tick.
// - Gap clock divides by ten, 70% duty, rising tick one, falling tick three.
// - Write clock divides by 23, 7/23 duty, rising tick one, falling tick three.
package tcs_pkg;
   localparam int CLK_KHZ = 100000;
   localparam int TICK_SLOW_KHZ = 640;
   localparam int TICK_FAST_KHZ = 960;
   localparam int TICK_SLOW_CYC = CLK_KHZ / TICK_SLOW_KHZ;
   localparam int TICK_FAST_CYC = CLK_KHZ / TICK_FAST_KHZ;
   localparam int GAP_DIV = 10;
   localparam int GAP_HIGH = 7;
   localparam int WCLK_DIV = 23;
   localparam int WCLK_HIGH = 7;
   localparam logic [3:0] CHK_PRESET_7T = 4'hB;
   localparam logic [3:0] CHK_PRESET_9T = 4'h7;
   localparam logic [3:0] CHK_LOCK = 4'hF;
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_CLOCKS = 4'h8;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam int CTRL_FAST = 0;
   localparam int CTRL_SPEED = 1;
   localparam int CTRL_PE = 2;
   localparam int CTRL_7T = 3;
   localparam int CTRL_WFM = 4;
   localparam int NSYNC = 6;
   localparam int SY_RCS = 0;
   localparam int SY_PHASE_WRITE_REQUEST = 1;
   localparam int SY_RESUME = 2;
   localparam int SY_PARITY = 3;
   localparam int SY_PROT = 4;
   localparam int SY_SCAN = 5;
endpackage : tcs_pkg

// ### test/tcs_host_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Storage channel host and scanner loop
// ----------------------------------------
module tcs_host_model
(
   input wire logic clk_i, // clock
   input wire logic rst_n_i, // reset, active low
   input wire logic req_i, // channel request
   output logic resume_o, // resume pulse
   output logic scan_o // scanner loop
);
   logic [4:0] cnt_r;
   logic [2:0] scan_r;
   // The answer comes late, so the request must stand across several scan loops.
   assign resume_o = cnt_r >= 5'h10 && cnt_r < 5'h16;
   assign scan_o = scan_r[2];
   always_ff @(posedge clk_i or negedge rst_n_i)
      if (!rst_n_i)
         {cnt_r, scan_r} <= 8'h00;
      else
         {cnt_r, scan_r} <= {(cnt_r != 5'h00 || req_i) ? cnt_r + 5'h01 : 5'h00, scan_r + 3'h1};
endmodule : tcs_host_model

// ### test/tcs_chk.sv
`timescale 1ns/100ps
module tcs_chk
(
   input wire logic MCLK_I, // clock
   input wire logic ARST_N_I, // reset
   input wire logic PROTECT_I, // in
   input wire logic BUFFERED_START_STROBE_I, // in
   input wire logic CONTROLLER_CLEAR_I, // in
   input wire logic MOTION_START_STROBE_I, // in
   input wire logic STAGE2_FULL_I, // in
   input wire logic RESUME_I, // in
   input wire logic BLOCK_ACTIVE_O, // out
   input wire logic FETCH_LIMIT_WORD_O, // out
   input wire logic CHANNEL_PROTECT_O, // out
   input wire logic LIMIT_ADDR_LOAD_O, // out
   input wire logic REQUEST_O, // out
   input wire logic WORD_STROBE_O, // out
   input wire logic FIRST_WORD_PENDING_O, // out
   input wire logic ADVANCE_WRITE_STROBE_O, // out
   input wire logic LOCKOUT_O, // out
   input wire logic DATA_REQUEST_O // out
);
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (!ARST_N_I);
   // Resume crosses a pin synchroniser, hence windows of a few cycles.
   sequence s_req_gone; ##[2:8] !REQUEST_O; endsequence
   sequence s_word; ##[2:8] WORD_STROBE_O; endsequence
   property p_blk_set; BUFFERED_START_STROBE_I |=> BLOCK_ACTIVE_O && FETCH_LIMIT_WORD_O
      && CHANNEL_PROTECT_O == $past(PROTECT_I); endproperty
   a_blk_set: assert property (p_blk_set) else $error("block start flags wrong");
   property p_blk_clr; CONTROLLER_CLEAR_I && !BUFFERED_START_STROBE_I |=> !BLOCK_ACTIVE_O
      && !FETCH_LIMIT_WORD_O && !CHANNEL_PROTECT_O; endproperty
   a_blk_clr: assert property (p_blk_clr) else $error("clear left block flags");
   property p_lim; $rose(FETCH_LIMIT_WORD_O) |-> !LIMIT_ADDR_LOAD_O; endproperty
   a_lim: assert property (p_lim) else $error("limit load not armed");
   property p_grant; $rose(RESUME_I) |-> s_req_gone; endproperty
   a_grant: assert property (p_grant) else $error("request kept after resume");
   property p_word; $fell(RESUME_I) |-> s_word; endproperty
   a_word: assert property (p_word) else $error("no word strobe after resume");
   property p_first; MOTION_START_STROBE_I |=> FIRST_WORD_PENDING_O; endproperty
   a_first: assert property (p_first) else $error("first word flag not set");
   property p_lock; LOCKOUT_O |-> $past(ADVANCE_WRITE_STROBE_O) && !$past(STAGE2_FULL_I);
   endproperty
   a_lock: assert property (p_lock) else $error("lockout without cause");
   property p_dreq; $rose(DATA_REQUEST_O) |-> !$past(BLOCK_ACTIVE_O); endproperty
   a_dreq: assert property (p_dreq) else $error("data request in block mode");
endmodule : tcs_chk
bind tcs_transfer_sequencer tcs_chk u_chk (.*);

// ### test/tcs_transfer_sequencer_tb_top.sv
`timescale 1ns/100ps
module tcs_transfer_sequencer_tb_top;
   import tcs_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [31:0] wd = 32'h0, q;
   logic [6:0] pv = 7'h00;
   logic [9:0] lv = 10'h000;
   wire [12:0] ob;
   wire [31:0] rdat;
   wire wtr, resume, scan;
   int error_cnt = 0, n_compared = 0;
   tcs_transfer_sequencer dut
   (
      .MCLK_I(clk), .ARST_N_I(rst_n), .CE_I(1'b1), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
      .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(4'hF), .AVS_READDATA_O(rdat),
      .AVS_WAITREQUEST_O(wtr), .STAGE1_FULL_I(lv[0]), .STAGE2_FULL_I(lv[1]),
      .WRITE_MOTION_I(lv[2]), .READ_MOTION_I(lv[3]), .MOTION_START_STROBE_I(pv[0]),
      .WRITE_MOTION_START_I(pv[1]), .BUFFERED_START_STROBE_I(pv[2]),
      .REGISTER_READ_STROBE_I(pv[3]), .REGISTER_WRITE_STROBE_I(pv[4]),
      .CONTROLLER_CLEAR_I(pv[5]), .FILE_MARK_I(lv[4]), .END_OF_TAPE_I(lv[5]),
      .LAST_WORD_I(lv[6]), .BUSY_I(lv[9]), .PROTECT_I(lv[7]), .ADDR_INCREMENT_PULSE_I(pv[6]),
      .READ_CHAR_STROBE_I(lv[8]), .PHASE_WRITE_REQUEST_I(1'b0), .RESUME_I(resume),
      .PARITY_FAULT_I(resume), .PROTECT_FAULT_I(lv[3]), .SCAN_IN_I(scan), .SCAN_OUT_O(),
      .STAGE_MOVE_PULSE_O(ob[0]), .DATA_REQUEST_O(ob[5]), .LOST_DATA_O(ob[6]),
      .WRITE_END_O(ob[11]), .WRITE_CHAR_STROBE_O(ob[1]), .ADVANCE_WRITE_STROBE_O(ob[2]),
      .LOCKOUT_O(ob[12]), .FIRST_WORD_PENDING_O(ob[7]), .RECORD_END_SEQUENCE_O(ob[8]),
      .CYCLIC_CHECK_CHAR_O(), .LONGITUDINAL_CHECK_CHAR_O(), .BLOCK_ACTIVE_O(ob[10]),
      .FETCH_LIMIT_WORD_O(), .CHANNEL_PROTECT_O(), .LIMIT_ADDR_LOAD_O(ob[9]),
      .REQUEST_O(ob[3]), .WORD_STROBE_O(ob[4]), .MEMORY_WRITE_ENABLE_O(),
      .GAP_TIMING_CLOCK_O(), .PHASE_CHAR_CLOCK_O(), .PHASE_BIT_CLOCK_O()
   );
   tcs_host_model u_host (.clk_i(clk), .rst_n_i(rst_n), .req_i(ob[3]), .resume_o(resume),
      .scan_o(scan));
   task end_sim;
      $display("compared %0d mismatched %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : end_sim
   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      n_compared++;
      if (s !== e)
      begin
         error_cnt++;
         $display("CHECK FAILED %s expected %0h seen %0h", n, e, s);
      end
   endtask : chk
   // Waits are bounded; one that runs out ends the run as a mismatch.
   task wt(input int k);
      int i;
      for (i = 0; i < 9000 && ob[k] !== 1'b1; i++)
         @(posedge clk);
      if (i == 9000)
      begin
         chk("wait", 32'h1, 32'h0);
         end_sim;
      end
   endtask : wt
   task av(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
      int i;
      @(posedge clk);
      {rd, wr, adr, wd} <= {!w, w, a, d};
      for (i = 0; i < 20; i++)
      begin
         @(posedge clk);
         if (wtr === 1'b0)
            break;
      end
      r = rdat;
      {rd, wr} <= 2'h0;
      if (i == 20)
      begin
         chk("bus", 32'h1, 32'h0);
         end_sim;
      end
   endtask : av
   task pul(input int b);
      @(posedge clk);
      pv[b] <= 1'b1;
      @(posedge clk);
      pv[b] <= 1'b0;
      @(posedge clk);
   endtask : pul
   initial
   begin
      forever
         #5 clk = ~clk;
   end
   initial
   begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      av(1'b0, ADDR_CTRL, 32'h0, q);
      chk("ctrl reset", CTRL_RESET, q);
      av(1'b1, ADDR_CTRL, 32'h13, q);
      av(1'b0, ADDR_CTRL, 32'h0, q);
      chk("ctrl", 32'h13, q);
      av(1'b0, 4'hC, 32'h0, q);
      chk("unmapped", 32'h0, q);
      lv <= 10'h080;
      pul(2);
      chk("block", 32'h1, ob[10]);
      chk("limit armed", 32'h0, ob[9]);
      wt(3);
      wt(4);
      chk("request", 32'h0, ob[3]);
      av(1'b0, ADDR_STATUS, 32'h0, q);
      chk("status", {16'h0000, CHK_PRESET_9T, 12'h470}, q);
      pul(6);
      chk("limit loaded", 32'h1, ob[9]);
      pul(5);
      chk("block clear", 32'h0, ob[10]);
      lv <= 10'h004;
      pul(1);
      chk("data request", 32'h1, ob[5]);
      pul(4);
      chk("request clear", 32'h0, ob[5]);
      wt(1);
      pul(0);
      chk("first word", 32'h1, ob[7]);
      wt(2);
      @(posedge clk);
      chk("record end", 32'h1, ob[8]);
      chk("lockout", 32'h1, ob[12]);
      wt(1);
      @(posedge clk);
      chk("no loss", 32'h0, ob[6]);
      chk("write end", 32'h1, ob[11]);
      chk("first word done", 32'h0, ob[7]);
      lv <= 10'h049;
      wt(0);
      repeat (2) @(posedge clk);
      chk("read request", 32'h1, ob[5]);
      lv <= 10'h14B;
      repeat (6) @(posedge clk);
      lv <= 10'h04B;
      @(posedge clk);
      chk("lost", 32'h1, ob[6]);
      chk("loss clears request", 32'h0, ob[5]);
      end_sim;
   end
endmodule : tcs_transfer_sequencer_tb_top
